/* File: src/rss_restart_search.sv */
// Restart and speed search sequencer with APB register file and interrupt.
// Assumes protection logic and current sampling share i_clock; pins are synchronised.
`timescale 1ns/10ps
`default_nettype none

module rss_restart_search
  import rss_pkg::*;
#(
  parameter int P_TICK_CYC = TICK_CYC,
  parameter int P_RIDE_CYC = RIDE_CYC,
  parameter int P_PI_CYC   = PI_CYC
) (
  input  wire logic        i_clock,
  input  wire logic        i_arst_n,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_power_ok,
  input  wire logic        i_run_cmd,
  input  wire logic        i_fault_reset,
  input  wire logic        i_trip,
  input  wire logic [2:0]  i_trip_cause,
  input  wire logic [15:0] i_current,
  input  wire logic [15:0] i_cmd_freq,
  output logic      [15:0] o_freq,
  output logic      [9:0]  o_volt,
  output logic             o_gate_en,
  output logic             o_open_collector_output,
  output logic             o_relay_contact_output,
  output logic             o_irq
);

  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
                                        input logic [15:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp

  // Pin synchronisers: power, run, fault reset
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [2:0] pin_in;
  assign pin_in = {i_fault_reset, i_run_cmd, i_power_ok};
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
          sync1_r[g] <= 1'b0;
          sync2_r[g] <= 1'b0;
        end else begin
          sync1_r[g] <= pin_in[g];
          sync2_r[g] <= sync1_r[g];
        end
      end
    end
  endgenerate
  logic pwr_ok;
  logic run;
  logic frst_d_r;
  logic frst_pulse;
  assign pwr_ok = sync2_r[0];
  assign run    = sync2_r[1];
  assign frst_pulse = sync2_r[2] & ~frst_d_r;

  // APB slave, no wait cycle: pready answers in the first access cycle
  rss_cfg_t            cfg_r;
  logic [IRQ_W-1:0]    istat_r;
  logic [IRQ_W-1:0]    imask_r;
  logic [IRQ_W-1:0]    ev;
  rss_state_t          state_r;
  logic [3:0]          remain_r;
  logic                active_r;
  logic                wr_acc;
  logic                mapped;
  assign mapped = (i_paddr[7:5] == 3'h0) && (i_paddr[1:0] == 2'h0);
  assign wr_acc = i_psel & i_penable & o_pready & i_pwrite & mapped;

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0;
    end else begin
      o_pready  <= i_psel & ~i_penable;
      o_pslverr <= i_psel & ~i_penable & ~mapped;
      o_prdata  <= 32'h0;
      if (i_psel && !i_penable && !i_pwrite) begin
        case (i_paddr)
          OFS_CFG:   o_prdata <= {8'h0, cfg_r.search_current_limit, 4'h0,
                                  cfg_r.search_trigger_select, 3'h0, cfg_r.energy_save_percent};
          OFS_GAIN:  o_prdata <= {cfg_r.search_integral_gain, cfg_r.search_prop_gain};
          OFS_RST:   o_prdata <= {14'h0, cfg_r.restart_delay, 4'h0, cfg_r.restart_try_count};
          OFS_OSEL:  o_prdata <= {19'h0, cfg_r.relay_select, 3'h0, cfg_r.mo_select};
          OFS_RATED: o_prdata <= {16'h0, cfg_r.motor_rated_current};
          OFS_STAT:  o_prdata <= {o_freq, 3'h0, active_r, remain_r, 5'h0, state_r};
          OFS_ISTAT: o_prdata <= {27'h0, istat_r};
          OFS_IMASK: o_prdata <= {27'h0, imask_r};
          default:   o_prdata <= 32'h0;
        endcase
      end
    end
  end

  // Configuration; written percent, limit, try count and delay are clamped into their legal ranges
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cfg_r.energy_save_percent   <= 5'h0;
      cfg_r.search_trigger_select <= 4'h0;
      cfg_r.search_current_limit  <= LIM_DEF[7:0];
      cfg_r.search_prop_gain      <= KP_DEF;
      cfg_r.search_integral_gain  <= KI_DEF;
      cfg_r.restart_try_count     <= 4'h0;
      cfg_r.restart_delay         <= DLY_DEF[9:0];
      cfg_r.mo_select             <= MO_DEF;
      cfg_r.relay_select          <= RLY_DEF;
      cfg_r.motor_rated_current   <= RATED_DEF;
      imask_r                     <= '0;
    end else if (wr_acc) begin
      case (i_paddr)
        OFS_CFG: begin
          cfg_r.energy_save_percent   <= 5'(clamp({11'h0, i_pwdata[4:0]}, 16'h0, ES_MAX));
          cfg_r.search_trigger_select <= i_pwdata[11:8];
          cfg_r.search_current_limit  <= 8'(clamp({8'h0, i_pwdata[23:16]}, LIM_MIN, LIM_MAX));
        end
        OFS_GAIN: begin
          cfg_r.search_prop_gain     <= i_pwdata[15:0];
          cfg_r.search_integral_gain <= i_pwdata[31:16];
        end
        OFS_RST: begin
          cfg_r.restart_try_count <= 4'(clamp({12'h0, i_pwdata[3:0]}, 16'h0, TRY_MAX));
          cfg_r.restart_delay     <= 10'(clamp({6'h0, i_pwdata[17:8]}, 16'h0, DLY_MAX));
        end
        OFS_OSEL: begin
          cfg_r.mo_select    <= i_pwdata[4:0];
          cfg_r.relay_select <= i_pwdata[12:8];
        end
        OFS_RATED: cfg_r.motor_rated_current <= i_pwdata[15:0];
        OFS_IMASK: imask_r <= i_pwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // Sticky events; a new event wins over a write-one clear in the same cycle
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      istat_r <= '0;
      o_irq   <= 1'b0;
    end else begin
      if (wr_acc && i_paddr == OFS_ISTAT) begin
        istat_r <= (istat_r & ~i_pwdata[IRQ_W-1:0]) | ev;
      end else begin
        istat_r <= istat_r | ev;
      end
      o_irq <= |(istat_r & imask_r);
    end
  end

  // Time base: 100 ms ticks and PI update strobe
  logic [31:0] tick_cnt_r;
  logic [31:0] pi_cnt_r;
  logic        tick;
  logic        pi_stb;
  assign tick   = (tick_cnt_r == 32'(P_TICK_CYC - 1));
  assign pi_stb = (pi_cnt_r == 32'(P_PI_CYC - 1));
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tick_cnt_r <= 32'h0;
      pi_cnt_r   <= 32'h0;
      frst_d_r   <= 1'b0;
    end else begin
      tick_cnt_r <= tick ? 32'h0 : tick_cnt_r + 32'h1;
      pi_cnt_r   <= pi_stb ? 32'h0 : pi_cnt_r + 32'h1;
      frst_d_r   <= sync2_r[2];
    end
  end

  // Current limit check and PI terms, compared as products to avoid a divider
  logic [23:0] lim_prod;
  logic [23:0] cur_prod;
  logic        over_lim;
  logic [15:0] err;
  logic [9:0]  v_nom;
  logic [31:0] p_term;
  assign lim_prod = 24'(cfg_r.motor_rated_current * cfg_r.search_current_limit);
  assign cur_prod = 24'(i_current * 8'd100);
  assign over_lim = cur_prod > lim_prod;
  assign err      = over_lim ? 16'h0 : 16'((lim_prod - cur_prod) >> 7);
  assign p_term   = err * cfg_r.search_prop_gain;
  assign v_nom    = V_FULL - 10'(cfg_r.energy_save_percent) * 10'(V_PER_PCT);

  // Sequencer
  logic [31:0] integ_r;
  logic [31:0] dv;
  logic [31:0] ride_cnt_r;
  logic [9:0]  dly_cnt_r;
  logic [8:0]  hold_cnt_r;
  logic        hold_r;
  logic [15:0] saved_cmd_r;
  logic [2:0]  cause_r;
  logic        first_r;
  logic        ipf_r;
  logic        suppress;
  assign dv = (p_term + integ_r) >> GAIN_SH;
  assign suppress = (cause_r == CAUSE_LV) || (cause_r == CAUSE_EST) ||
                    (cause_r == CAUSE_OH) || (cause_r == CAUSE_HW);

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_r     <= ST_IDLE;
      o_freq      <= 16'h0;
      o_volt      <= 10'h0;
      o_gate_en   <= 1'b0;
      active_r    <= 1'b0;
      integ_r     <= 32'h0;
      ride_cnt_r  <= 32'h0;
      dly_cnt_r   <= 10'h0;
      hold_cnt_r  <= 9'h0;
      hold_r      <= 1'b0;
      remain_r    <= 4'h0;
      saved_cmd_r <= 16'h0;
      cause_r     <= 3'h0;
      first_r     <= 1'b1;
      ipf_r       <= 1'b0;
      ev          <= '0;
    end else begin
      ev <= '0;
      if (frst_pulse) remain_r <= cfg_r.restart_try_count;
      if (hold_r && tick) begin
        if (hold_cnt_r == 9'(HOLD_TICKS - 1)) begin
          hold_r   <= 1'b0;
          remain_r <= cfg_r.restart_try_count;
        end else begin
          hold_cnt_r <= hold_cnt_r + 9'h1;
        end
      end
      ride_cnt_r <= pwr_ok ? 32'h0 : ride_cnt_r + 32'h1;
      case (state_r)
        ST_IDLE: begin
          o_gate_en <= 1'b0;
          o_freq    <= 16'h0;
          o_volt    <= 10'h0;
          if (run && pwr_ok) begin
            first_r     <= 1'b0;
            saved_cmd_r <= i_cmd_freq;
            o_gate_en   <= 1'b1;
            if (cfg_r.search_trigger_select[TRIG_ACC] ||
                (first_r && cfg_r.search_trigger_select[TRIG_PON])) begin
              state_r  <= ST_SEARCH;
              o_freq   <= i_cmd_freq;
              integ_r  <= 32'h0;
              active_r <= 1'b1;
              ev[IRQ_SSTART] <= 1'b1;
            end else begin
              state_r <= ST_ACCEL;
              o_volt  <= v_nom;
            end
          end
        end
        ST_SEARCH: begin
          if (pi_stb) begin
            if (over_lim) begin
              o_freq <= (o_freq > F_STEP) ? o_freq - F_STEP : 16'h0;
            end else begin
              integ_r <= integ_r + 32'(err * cfg_r.search_integral_gain);
              if (32'(o_volt) + dv >= 32'(v_nom)) begin
                o_volt   <= v_nom;
                state_r  <= ST_ACCEL;
                active_r <= 1'b0;
                ev[IRQ_SDONE] <= 1'b1;
              end else begin
                o_volt <= o_volt + 10'(dv);
              end
            end
          end
        end
        ST_ACCEL: begin
          o_volt <= v_nom;
          if (pi_stb) begin
            if (o_freq + ACC_STEP >= saved_cmd_r) begin
              o_freq  <= saved_cmd_r;
              state_r <= ST_RUN;
            end else begin
              o_freq <= o_freq + ACC_STEP;
            end
          end
        end
        ST_RUN: begin
          o_volt      <= v_nom;
          o_freq      <= i_cmd_freq;
          saved_cmd_r <= i_cmd_freq;
        end
        ST_TRIP: begin
          o_gate_en <= 1'b0;
          // Only a real supply loss restarts on power return; a protection LV waits
          if (ipf_r && pwr_ok && run &&
              cfg_r.search_trigger_select[TRIG_IPF]) begin
            state_r   <= ST_SEARCH;
            ipf_r     <= 1'b0;
            o_gate_en <= 1'b1;
            o_volt    <= 10'h0;
            integ_r   <= 32'h0;
            active_r  <= 1'b1;
            ev[IRQ_SSTART] <= 1'b1;
          end else if (frst_pulse) begin
            ipf_r <= 1'b0;
            if (!run) begin
              state_r <= ST_IDLE;
            end else if (cfg_r.search_trigger_select[TRIG_RST]) begin
              state_r   <= ST_SEARCH;
              o_gate_en <= 1'b1;
              o_volt    <= 10'h0;
              integ_r   <= 32'h0;
              active_r  <= 1'b1;
              ev[IRQ_SSTART] <= 1'b1;
            end else begin
              state_r   <= ST_ACCEL;
              o_gate_en <= 1'b1;
              o_freq    <= 16'h0;
            end
          end
        end
        ST_WAIT: begin
          o_gate_en <= 1'b0;
          if (tick) dly_cnt_r <= dly_cnt_r + 10'h1;
          if (dly_cnt_r >= cfg_r.restart_delay) begin
            remain_r   <= remain_r - 4'h1;
            state_r    <= ST_SEARCH;
            o_gate_en  <= 1'b1;
            o_volt     <= 10'h0;
            integ_r    <= 32'h0;
            active_r   <= 1'b1;
            hold_r     <= 1'b1;
            hold_cnt_r <= 9'h0;
            ev[IRQ_SSTART]  <= 1'b1;
            ev[IRQ_RESTART] <= 1'b1;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
      // Frequency is held in o_freq across a trip so the search can resume from it
      if (state_r == ST_SEARCH || state_r == ST_ACCEL || state_r == ST_RUN) begin
        if (!run) begin
          state_r   <= ST_IDLE;
          active_r  <= 1'b0;
          o_gate_en <= 1'b0;
        end else if (ride_cnt_r >= 32'(P_RIDE_CYC)) begin
          state_r   <= ST_TRIP;
          cause_r   <= CAUSE_LV;
          ipf_r     <= 1'b1;
          o_gate_en <= 1'b0;
          active_r  <= 1'b0;
          hold_r    <= 1'b0;
          ev[IRQ_TRIP] <= 1'b1;
        end else if (i_trip) begin
          cause_r   <= i_trip_cause;
          o_gate_en <= 1'b0;
          active_r  <= 1'b0;
          hold_r    <= 1'b0;
          dly_cnt_r <= 10'h0;
          ev[IRQ_TRIP] <= 1'b1;
          if (remain_r != 4'h0 && !(i_trip_cause == CAUSE_LV ||
              i_trip_cause == CAUSE_EST || i_trip_cause == CAUSE_OH ||
              i_trip_cause == CAUSE_HW)) begin
            state_r <= ST_WAIT;
          end else begin
            state_r <= ST_TRIP;
            if (remain_r == 4'h0 && !suppress) ev[IRQ_EXHAUST] <= 1'b1;
          end
        end
      end
    end
  end

  // Search indication on the selectable outputs
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_open_collector_output <= 1'b0;
      o_relay_contact_output  <= 1'b0;
    end else begin
      o_open_collector_output <= (cfg_r.mo_select == SEL_SEARCH) & active_r;
      o_relay_contact_output  <= (cfg_r.relay_select == SEL_SEARCH) & active_r;
    end
  end

endmodule : rss_restart_search

`default_nettype wire

/* File: src/rss_pkg.sv */
// Constants, register map and types for the restart and speed search sequencer.
// Assumes a single 200 MHz clock; every time figure is converted to cycles here, the hold time to ticks.
package rss_pkg;
  localparam int CLK_MHZ    = 200;
  localparam int TICK_MS    = 100;
  localparam int TICK_CYC   = TICK_MS * 1000 * CLK_MHZ;
  localparam int RIDE_MS    = 15;
  localparam int RIDE_CYC   = RIDE_MS * 1000 * CLK_MHZ;
  localparam int PI_US      = 50;
  localparam int PI_CYC     = PI_US * CLK_MHZ;
  localparam int HOLD_S     = 30;
  localparam int HOLD_TICKS = HOLD_S * 1000 / TICK_MS;

  localparam logic [7:0] OFS_CFG   = 8'h00;
  localparam logic [7:0] OFS_GAIN  = 8'h04;
  localparam logic [7:0] OFS_RST   = 8'h08;
  localparam logic [7:0] OFS_OSEL  = 8'h0c;
  localparam logic [7:0] OFS_RATED = 8'h10;
  localparam logic [7:0] OFS_STAT  = 8'h14;
  localparam logic [7:0] OFS_ISTAT = 8'h18;
  localparam logic [7:0] OFS_IMASK = 8'h1c;

  localparam logic [15:0] ES_MAX    = 16'h001e;
  localparam logic [15:0] LIM_MIN   = 16'h0050;
  localparam logic [15:0] LIM_MAX   = 16'h00c8;
  localparam logic [15:0] LIM_DEF   = 16'h0064;
  localparam logic [15:0] KP_DEF    = 16'h0064;
  localparam logic [15:0] KI_DEF    = 16'h00c8;
  localparam logic [15:0] TRY_MAX   = 16'h000a;
  localparam logic [15:0] DLY_MAX   = 16'h0258;
  localparam logic [15:0] DLY_DEF   = 16'h000a;
  localparam logic [15:0] RATED_DEF = 16'h0064;
  localparam logic [4:0]  SEL_SEARCH = 5'h0f;
  localparam logic [4:0]  MO_DEF    = 5'h0c;
  localparam logic [4:0]  RLY_DEF   = 5'h11;

  localparam logic [9:0]  V_FULL    = 10'h3e8;
  localparam logic [4:0]  V_PER_PCT = 5'h0a;
  localparam logic [15:0] F_STEP    = 16'h0004;
  localparam logic [15:0] ACC_STEP  = 16'h0002;
  localparam int          GAIN_SH   = 10;

  localparam int TRIG_ACC = 0;
  localparam int TRIG_RST = 1;
  localparam int TRIG_IPF = 2;
  localparam int TRIG_PON = 3;

  localparam logic [2:0] CAUSE_LV  = 3'h1;
  localparam logic [2:0] CAUSE_EST = 3'h2;
  localparam logic [2:0] CAUSE_OH  = 3'h3;
  localparam logic [2:0] CAUSE_HW  = 3'h4;

  localparam int IRQ_W       = 5;
  localparam int IRQ_TRIP    = 0;
  localparam int IRQ_SSTART  = 1;
  localparam int IRQ_SDONE   = 2;
  localparam int IRQ_RESTART = 3;
  localparam int IRQ_EXHAUST = 4;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ACCEL  = 3'b001,
    ST_RUN    = 3'b010,
    ST_SEARCH = 3'b011,
    ST_TRIP   = 3'b100,
    ST_WAIT   = 3'b101
  } rss_state_t;

  typedef struct packed {
    logic [4:0]  energy_save_percent;
    logic [3:0]  search_trigger_select;
    logic [7:0]  search_current_limit;
    logic [15:0] search_prop_gain;
    logic [15:0] search_integral_gain;
    logic [3:0]  restart_try_count;
    logic [9:0]  restart_delay;
    logic [4:0]  mo_select;
    logic [4:0]  relay_select;
    logic [15:0] motor_rated_current;
  } rss_cfg_t;
endpackage : rss_pkg

/* File: bench/rss_restart_search_sva.sv */
// Checker on the sequencer ports: APB timing, search steps, power loss.
// Assumes both output selects hold the search code while searching.
`timescale 1ns/10ps
`default_nettype none
module rss_restart_search_sva
  import rss_pkg::*;
#(
  parameter int P_RIDE_CYC = RIDE_CYC
) (
  input wire logic        i_clock,
  input wire logic        i_arst_n,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic [7:0]  i_paddr,
  input wire logic        i_power_ok,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic [15:0] o_freq,
  input wire logic [9:0]  o_volt,
  input wire logic        o_gate_en,
  input wire logic        o_open_collector_output,
  input wire logic        o_relay_contact_output
);
  int   lo_cnt;
  logic srch;
  assign srch = o_open_collector_output && o_relay_contact_output;
  // Saturates so a long loss is flagged once, not wrapped
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) lo_cnt <= 0;
    else if (i_power_ok) lo_cnt <= 0;
    else if (lo_cnt < P_RIDE_CYC + 9) lo_cnt <= lo_cnt + 1;
  end
  default clocking dc @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  sequence s_setup;
    i_psel && !i_penable;
  endsequence
  sequence s_search2;
    srch ##1 srch;
  endsequence
  a_ready_pulse: assert property (o_pready |=> !o_pready) // bus
    else $error("ready held over one cycle");
  a_setup_answer: assert property (s_setup |=> o_pready) // bus
    else $error("no ready in first access cycle");
  a_err_decode: assert property (o_pready |-> // bus
    o_pslverr == (i_paddr >= 8'h20 || i_paddr[1:0] != 2'h0))
    else $error("error flag does not match address");
  a_err_alone: assert property (o_pslverr |-> o_pready) // bus
    else $error("error flag without ready");
  a_rdata_idle: assert property (!o_pready |-> o_prdata == 32'h0) // bus
    else $error("read data outside ready");
  a_volt_cap: assert property (o_volt <= V_FULL)
    else $error("voltage above maximum");
  a_search_freq: assert property (s_search2 |-> o_freq <= $past(o_freq))
    else $error("frequency rose during search");
  a_search_volt: assert property (s_search2 |-> o_volt >= $past(o_volt))
    else $error("voltage fell during search");
  a_power_trip: assert property (lo_cnt == P_RIDE_CYC + 6 |-> !o_gate_en ##1
    (!o_gate_en && $stable(o_freq)))
    else $error("output not held after power loss");
endmodule : rss_restart_search_sva
bind rss_restart_search rss_restart_search_sva #(.P_RIDE_CYC(P_RIDE_CYC)) sva_inst (
  .i_clock, .i_arst_n, .i_psel, .i_penable, .i_paddr, .i_power_ok, .o_prdata, .o_pready,
  .o_pslverr, .o_freq, .o_volt, .o_gate_en, .o_open_collector_output, .o_relay_contact_output);
`default_nettype wire

/* File: bench/rss_motor_model.sv */
// Motor load model: current follows voltage, overload on command.
// Assumes one clock shared with the drive; no output means no current.
`timescale 1ns/10ps
`default_nettype none
module rss_motor_model (
  input  wire logic        i_clock,
  input  wire logic        i_arst_n,
  input  wire logic        i_gate_en,
  input  wire logic [9:0]  i_volt,
  input  wire logic        i_overload,
  output logic      [15:0] o_current
);
  // Registered: the drive sees current a cycle late, as from a sensor
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) o_current <= 16'h0000;
    else if (!i_gate_en) o_current <= 16'h0000;
    else if (i_overload) o_current <= 16'h0190;
    else o_current <= {6'h00, i_volt} / 16'h000a;
  end
endmodule : rss_motor_model
`default_nettype wire

/* File: bench/rss_restart_search_bench.sv */
// Self-checking bench for the restart and speed search sequencer.
// Assumes shortened tick, ride and PI periods; motor model on the output.
`timescale 1ns/10ps
`default_nettype none
module rss_restart_search_bench;
  import rss_pkg::*;
  localparam int RIDE = 30;
  logic        clk = 1'b0;
  logic        rst_n, psel, pen, pwrite, pok, run, frst, trip, ovl;
  logic        pready, pslverr, gate, oc, rly, irq;
  logic [7:0]  paddr;
  logic [2:0]  cause;
  logic [9:0]  volt;
  logic [15:0] cur, cmd, freq, f;
  logic [31:0] pwdata, prdata, d;
  logic [32:0] e, m;
  logic [32:0] exp_q[$];
  logic [32:0] msk_q[$];
  int          mismatches, comparisons, seed, i;
  always #2.5 clk = ~clk;
  rss_restart_search #(.P_TICK_CYC(20), .P_RIDE_CYC(RIDE), .P_PI_CYC(4)) rss_restart_search_inst (
    .i_clock(clk), .i_arst_n(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_power_ok(pok), .i_run_cmd(run), .i_fault_reset(frst),
    .i_trip(trip), .i_trip_cause(cause), .i_current(cur), .i_cmd_freq(cmd), .o_freq(freq),
    .o_volt(volt), .o_gate_en(gate), .o_open_collector_output(oc),
    .o_relay_contact_output(rly), .o_irq(irq));
  rss_motor_model rss_motor_model_inst (.i_clock(clk), .i_arst_n(rst_n), .i_gate_en(gate),
    .i_volt(volt), .i_overload(ovl), .o_current(cur));
  task finish_test;
    $display("Counts: %0d compared, %0d bad", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  task hang(input string n);
    mismatches++;
    $display("BAD %s exp done got timeout", n);
    finish_test();
  endtask : hang
  task chk(input string n, input logic [15:0] x, input logic [15:0] g);
    comparisons++;
    if (g !== x) begin
      mismatches++;
      $display("BAD %s exp %h got %h", n, x, g);
    end
  endtask : chk
  // Every transfer notes its expected {error, data}; the watcher compares
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] dd,
            input logic [32:0] x, input logic [32:0] mk);
    int k;
    exp_q.push_back(x);
    msk_q.push_back(mk);
    @(posedge clk);
    psel <= 1'b1; pen <= 1'b0; pwrite <= w; paddr <= a; pwdata <= dd;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) hang("apb");
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : xfer
  task wr(input logic [7:0] a, input logic [31:0] dd);
    xfer(1'b1, a, dd, 33'h0, 33'h1_0000_0000);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] mk);
    xfer(1'b0, a, 32'h0, {1'b0, x}, {1'b1, mk});
  endtask : rd
  task stat(input logic [3:0] r, input logic [2:0] s, input logic [31:0] mk);
    rd(OFS_STAT, {20'h0, r, 5'h0, s}, mk);
  endtask : stat
  task wait_srch(input logic lv);
    int k;
    k = 0;
    while (oc !== lv && k < 3000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 3000) hang("search");
  endtask : wait_srch
  task restart;
    @(posedge clk) trip <= 1'b1;
    @(posedge clk) trip <= 1'b0;
    wait_srch(1'b1);
    wait_srch(1'b0);
  endtask : restart
  task fault_reset;
    @(posedge clk) frst <= 1'b1;
    repeat (4) @(posedge clk);
    frst <= 1'b0;
  endtask : fault_reset
  always @(posedge clk) begin
    if (psel && pen && pready === 1'b1) begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      comparisons++;
      if ((({pslverr, prdata} ^ e) & m) !== 33'h0) begin
        mismatches++;
        $display("BAD apb %h exp %h got %h", paddr, e & m, {pslverr, prdata} & m);
      end
    end
  end
  initial begin
    rst_n = 1'b0; psel = 1'b0; pen = 1'b0; pwrite = 1'b0; pok = 1'b1; run = 1'b0;
    frst = 1'b0; trip = 1'b0; ovl = 1'b0; paddr = 8'h00; cause = 3'h0;
    cmd = 16'h0400; pwdata = 32'h0; seed = 41;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(OFS_CFG, 32'h0064_0000, 32'hffff_ffff);
    rd(OFS_GAIN, 32'h00c8_0064, 32'hffff_ffff);
    rd(OFS_RST, 32'h0000_0a00, 32'hffff_ffff);
    rd(OFS_OSEL, 32'h0000_110c, 32'hffff_ffff);
    xfer(1'b0, 8'h20, 32'h0, {1'b1, 32'h0}, {1'b1, 32'hffff_ffff});
    xfer(1'b1, 8'h02, 32'h5, {1'b1, 32'h0}, 33'h1_0000_0000);
    wr(OFS_CFG, 32'h004f_001f);
    rd(OFS_CFG, 32'h0050_001e, 32'hffff_ffff);
    wr(OFS_CFG, 32'h00c9_0000);
    rd(OFS_CFG, 32'h00c8_0000, 32'hffff_ffff);
    wr(OFS_RST, 32'h0003_ff0f);
    rd(OFS_RST, 32'h0002_580a, 32'hffff_ffff);
    for (i = 0; i < 4; i++) begin
      d = $random(seed) & 32'h1fff_1fff;
      wr(OFS_GAIN, d);
      rd(OFS_GAIN, d, 32'hffff_ffff);
    end
    wr(OFS_GAIN, 32'h00c8_0064);
    wr(OFS_OSEL, 32'h0000_0f0f);
    wr(OFS_RST, 32'h0000_0202);
    wr(OFS_CFG, 32'h0064_0f0a);
    wr(OFS_IMASK, 32'h0000_0002);
    $display("Test registers done");
    @(posedge clk) run <= 1'b1;
    wait_srch(1'b1);
    chk("relay", 16'h1, {15'h0, rly});
    repeat (3) @(posedge clk);
    chk("irq set", 16'h1, {15'h0, irq});
    f = freq;
    ovl <= 1'b1;
    repeat (8) @(posedge clk);
    d = {22'h0, volt};
    repeat (12) @(posedge clk);
    chk("volt halt", d[15:0], {6'h0, volt});
    chk("freq fell", 16'h1, {15'h0, freq < f});
    ovl <= 1'b0;
    wait_srch(1'b0);
    chk("volt nominal", 16'h0384, {6'h0, volt});
    i = 0;
    while (freq !== cmd && i < 5000) begin
      @(posedge clk);
      i++;
    end
    if (i >= 5000) hang("run");
    chk("freq run", cmd, freq);
    rd(OFS_ISTAT, 32'h6, 32'h6);
    wr(OFS_ISTAT, 32'h1f);
    wr(OFS_IMASK, 32'h0);
    chk("irq clear", 16'h0, {15'h0, irq});
    $display("Test power on search done");
    @(posedge clk) pok <= 1'b0;
    repeat (RIDE - 10) @(posedge clk);
    pok <= 1'b1;
    repeat (5) @(posedge clk);
    chk("ride through", 16'h1, {15'h0, gate});
    pok <= 1'b0;
    repeat (RIDE + 10) @(posedge clk);
    chk("gate off", 16'h0, {15'h0, gate});
    f = freq;
    stat(4'h0, 3'h4, 32'h0000_0f07);
    pok <= 1'b1;
    wait_srch(1'b1);
    chk("freq resume", f, freq);
    wait_srch(1'b0);
    $display("Test power failure done");
    fault_reset();
    rd(OFS_STAT, 32'h200, 32'hf00);
    @(posedge clk) trip <= 1'b1;
    @(posedge clk) trip <= 1'b0;
    repeat (12) @(posedge clk);
    stat(4'h2, 3'h5, 32'h0000_0f07);
    wait_srch(1'b1);
    rd(OFS_STAT, 32'h100, 32'hf00);
    wait_srch(1'b0);
    restart();
    rd(OFS_STAT, 32'h000, 32'hf00);
    @(posedge clk) trip <= 1'b1;
    @(posedge clk) trip <= 1'b0;
    repeat (60) @(posedge clk);
    stat(4'h0, 3'h4, 32'h0000_0f07);
    rd(OFS_ISTAT, 32'h10, 32'h10);
    fault_reset();
    wait_srch(1'b1);
    wait_srch(1'b0);
    restart();
    rd(OFS_STAT, 32'h100, 32'hf00);
    repeat (6200) @(posedge clk);
    rd(OFS_STAT, 32'h200, 32'hf00);
    $display("Test auto restart done");
    for (i = 1; i < 5; i++) begin
      @(posedge clk);
      trip <= 1'b1;
      cause <= i[2:0];
      @(posedge clk) trip <= 1'b0;
      repeat (60) @(posedge clk);
      stat(4'h2, 3'h4, 32'h0000_0f07);
      fault_reset();
      wait_srch(1'b1);
      wait_srch(1'b0);
    end
    chk("irq masked", 16'h0, {15'h0, irq});
    @(posedge clk) run <= 1'b0;
    repeat (5) @(posedge clk);
    chk("gate stop", 16'h0, {15'h0, gate});
    $display("Test suppressed causes done");
    wr(OFS_CFG, 32'h0064_000a);
    @(posedge clk) run <= 1'b1;
    repeat (20) @(posedge clk);
    chk("plain start", 16'h0, {15'h0, oc});
    chk("gate on", 16'h1, {15'h0, gate});
    stat(4'h2, 3'h1, 32'h0000_0f07);
    $display("Test plain start done");
    finish_test();
  end
endmodule : rss_restart_search_bench
`default_nettype wire
